//--- sxa_pkg.sv
// Package for the stack transfer and exclusive access sequencer.
// Assumes a single-clock core with a simple request/ready memory port.
package sxa_pkg;
    localparam int SXA_NREG = 16;
    localparam logic [3:0] SXA_SP_IDX = 4'hD;
    localparam logic [3:0] SXA_LR_IDX = 4'hE;
    localparam logic [3:0] SXA_PC_IDX = 4'hF;
    localparam logic [31:0] SXA_WORD_STEP = 32'h0000_0004;
    localparam logic [31:0] SXA_ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] SXA_DATA_RST = 32'h0000_0000;
    localparam logic [31:0] SXA_STATUS_OK = 32'h0000_0000;
    localparam logic [31:0] SXA_STATUS_FAIL = 32'h0000_0001;
    localparam int SXA_THUMB_BIT = 0;
    localparam logic [1:0] SXA_SIZE_BYTE = 2'h0;
    localparam logic [1:0] SXA_SIZE_HALF = 2'h1;
    localparam logic [1:0] SXA_SIZE_WORD = 2'h2;

    typedef enum logic [2:0] {
        SXA_OP_NONE = 3'b000,
        SXA_OP_STORE_MULTI = 3'b001,
        SXA_OP_LOAD_MULTI = 3'b010,
        SXA_OP_LOAD_EXCL = 3'b011,
        SXA_OP_STORE_EXCL = 3'b100,
        SXA_OP_CLEAR_EXCL = 3'b101
    } sxa_op_t;

    typedef enum logic [2:0] {
        SXA_ST_IDLE = 3'b000,
        SXA_ST_STM = 3'b001,
        SXA_ST_LDM = 3'b010,
        SXA_ST_LDX = 3'b011,
        SXA_ST_STX = 3'b100,
        SXA_ST_DONE = 3'b101
    } sxa_state_t;
endpackage : sxa_pkg

//--- sxa_stack_excl.sv
// Sequencer for stack push/pop and exclusive load/store/clear.
// Assumes register file reads/writes and a memory port with ready handshake.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Store highest register down, highest address first
// - Load registers ascending from lowest address
// - Store tops at sp-4; load starts at sp
// - Stack pointer ends at lowest/above-highest word
// - Loaded program counter branches, bit0 sets thumb
// - These instructions never touch condition flags
// - Exclusive load reads word, byte or half
// - Status zero on store, one when suppressed
// - Success only if no snoop hit the location, except a snoop in the cycle the store is accepted
// - After clear, next exclusive store fails
// - Multi transfers use consecutive four-byte words
module sxa_stack_excl
    import sxa_pkg::*;
#(
    parameter int NREG = SXA_NREG
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic op_valid,
    input wire sxa_op_t op_code,
    input wire logic [NREG-1:0] op_reglist,
    input wire logic [31:0] op_addr,
    input wire logic [1:0] op_size,
    input wire logic [31:0] op_store_data,
    input wire logic [31:0] sp_value,
    input wire logic [31:0] reg_rd_data,
    input wire logic mem_ready,
    input wire logic [31:0] mem_rdata,
    input wire logic snoop_valid,
    input wire logic [31:0] snoop_addr,
    output logic op_ready,
    output logic op_done,
    output logic [3:0] reg_rd_idx,
    output logic reg_wr_en,
    output logic [3:0] reg_wr_idx,
    output logic [31:0] reg_wr_data,
    output logic sp_wr_en,
    output logic [31:0] sp_wr_data,
    output logic branch_en,
    output logic [31:0] branch_addr,
    output logic thumb_flag,
    output logic mem_req,
    output logic mem_we,
    output logic [1:0] mem_size,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic flags_we,
    output logic monitor_armed
);
    sxa_state_t state_q;
    logic [NREG-1:0] list_q;
    logic [31:0] addr_q;
    logic [31:0] mon_addr_q;
    logic mon_q;
    logic [1:0] size_q;
    logic [31:0] sdata_q;
    logic pend_pc_q;
    logic [31:0] pc_val_q;
    logic [3:0] hi_idx;
    logic [3:0] cur_idx;
    logic [31:0] cnt_words;
    logic last_beat;
    logic beat_done;
    logic stx_pass;

    // Highest remaining bit and byte span of the new list
    always_comb begin
        hi_idx = 4'h0;
        cnt_words = 32'h0;
        for (int i = 0; i < NREG; i++) begin
            if (list_q[i]) begin
                hi_idx = 4'(i);
            end
            if (op_reglist[i]) begin
                cnt_words = cnt_words + SXA_WORD_STEP;
            end
        end
    end

    always_comb begin
        cur_idx = 4'h0;
        for (int i = NREG - 1; i >= 0; i--) begin
            if (list_q[i]) begin
                cur_idx = 4'(i);
            end
        end
        if (state_q == SXA_ST_STM) begin
            cur_idx = hi_idx;
        end
    end

    assign last_beat = ((list_q & ~(NREG'(1) << cur_idx)) == '0);
    assign beat_done = mem_req && mem_ready;
    assign stx_pass = mon_q && (mon_addr_q == addr_q);

    assign op_ready = (state_q == SXA_ST_IDLE);
    assign op_done = (state_q == SXA_ST_DONE);
    assign reg_rd_idx = cur_idx;
    assign mem_req = (state_q == SXA_ST_STM) || (state_q == SXA_ST_LDM)
        || (state_q == SXA_ST_LDX) || (state_q == SXA_ST_STX && stx_pass);
    assign mem_we = (state_q == SXA_ST_STM) || (state_q == SXA_ST_STX);
    assign mem_size = size_q;
    assign mem_addr = addr_q;
    assign mem_wdata = (state_q == SXA_ST_STM) ? reg_rd_data : sdata_q;
    assign flags_we = 1'b0;
    assign monitor_armed = mon_q;

    // Sequencer state
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= SXA_ST_IDLE;
        end else begin
            case (state_q)
                SXA_ST_IDLE: begin
                    if (op_valid) begin
                        case (op_code)
                            SXA_OP_STORE_MULTI: state_q <= SXA_ST_STM;
                            SXA_OP_LOAD_MULTI: state_q <= SXA_ST_LDM;
                            SXA_OP_LOAD_EXCL: state_q <= SXA_ST_LDX;
                            SXA_OP_STORE_EXCL: state_q <= SXA_ST_STX;
                            SXA_OP_CLEAR_EXCL: state_q <= SXA_ST_DONE;
                            default: state_q <= SXA_ST_IDLE;
                        endcase
                    end
                end
                SXA_ST_STM, SXA_ST_LDM: begin
                    if (beat_done && last_beat) begin
                        state_q <= SXA_ST_DONE;
                    end
                end
                SXA_ST_LDX: begin
                    if (beat_done) begin
                        state_q <= SXA_ST_DONE;
                    end
                end
                SXA_ST_STX: begin
                    if (!stx_pass || beat_done) begin
                        state_q <= SXA_ST_DONE;
                    end
                end
                SXA_ST_DONE: state_q <= SXA_ST_IDLE;
                default: state_q <= SXA_ST_IDLE;
            endcase
        end
    end

    // Operand capture and address stepping
    always_ff @(posedge clk) begin
        if (!nrst) begin
            list_q <= '0;
            addr_q <= SXA_ADDR_RST;
            size_q <= SXA_SIZE_WORD;
            sdata_q <= SXA_DATA_RST;
        end else if (state_q == SXA_ST_IDLE && op_valid) begin
            list_q <= op_reglist;
            size_q <= SXA_SIZE_WORD;
            sdata_q <= op_store_data;
            addr_q <= op_addr;
            if (op_code == SXA_OP_STORE_MULTI) begin
                // top word at sp minus four
                addr_q <= sp_value - SXA_WORD_STEP;
            end else if (op_code == SXA_OP_LOAD_MULTI) begin
                addr_q <= sp_value;
            end else begin
                size_q <= op_size;
            end
        end else if (beat_done && (state_q == SXA_ST_STM || state_q == SXA_ST_LDM)) begin
            list_q[cur_idx] <= 1'b0;
            if (state_q == SXA_ST_STM) begin
                addr_q <= addr_q - SXA_WORD_STEP;
            end else begin
                addr_q <= addr_q + SXA_WORD_STEP;
            end
        end
    end

    // Register writeback and stack pointer update
    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_wr_en <= 1'b0;
            reg_wr_idx <= 4'h0;
            reg_wr_data <= SXA_DATA_RST;
            sp_wr_en <= 1'b0;
            sp_wr_data <= SXA_ADDR_RST;
            pend_pc_q <= 1'b0;
            pc_val_q <= SXA_DATA_RST;
        end else begin
            reg_wr_en <= 1'b0;
            sp_wr_en <= 1'b0;
            if (state_q == SXA_ST_IDLE && op_valid) begin
                pend_pc_q <= 1'b0;
                if (op_code == SXA_OP_STORE_MULTI) begin
                    sp_wr_data <= sp_value - cnt_words;
                end else if (op_code == SXA_OP_LOAD_MULTI) begin
                    sp_wr_data <= sp_value + cnt_words;
                end
            end
            if (beat_done && state_q == SXA_ST_LDM) begin
                if (cur_idx == SXA_PC_IDX) begin
                    pend_pc_q <= 1'b1;
                    pc_val_q <= mem_rdata;
                end else begin
                    reg_wr_en <= 1'b1;
                    reg_wr_idx <= cur_idx;
                    reg_wr_data <= mem_rdata;
                end
            end
            if (beat_done && state_q == SXA_ST_LDX) begin
                reg_wr_en <= 1'b1;
                reg_wr_idx <= 4'h0;
                case (size_q)
                    SXA_SIZE_BYTE: reg_wr_data <= {24'h000000, mem_rdata[7:0]};
                    SXA_SIZE_HALF: reg_wr_data <= {16'h0000, mem_rdata[15:0]};
                    default: reg_wr_data <= mem_rdata;
                endcase
            end
            if (state_q == SXA_ST_STX && (!stx_pass || beat_done)) begin
                reg_wr_en <= 1'b1;
                reg_wr_idx <= 4'h0;
                reg_wr_data <= stx_pass ? SXA_STATUS_OK : SXA_STATUS_FAIL;
            end
            if ((state_q == SXA_ST_STM || state_q == SXA_ST_LDM) && beat_done && last_beat) begin
                sp_wr_en <= 1'b1;
            end
        end
    end

    // branch and thumb update after pop
    always_ff @(posedge clk) begin
        if (!nrst) begin
            branch_en <= 1'b0;
            branch_addr <= SXA_ADDR_RST;
            thumb_flag <= 1'b1;
        end else begin
            branch_en <= 1'b0;
            if (state_q == SXA_ST_DONE && pend_pc_q) begin
                branch_en <= 1'b1;
                branch_addr <= {pc_val_q[31:1], 1'b0};
                thumb_flag <= pc_val_q[SXA_THUMB_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mon_q <= 1'b0;
            mon_addr_q <= SXA_ADDR_RST;
        end else if (state_q == SXA_ST_IDLE && op_valid && op_code == SXA_OP_LOAD_EXCL) begin
            mon_q <= 1'b1;
            mon_addr_q <= op_addr;
        end else if (state_q == SXA_ST_IDLE && op_valid
            && (op_code == SXA_OP_CLEAR_EXCL || op_code == SXA_OP_STORE_EXCL)) begin
            mon_q <= (op_code == SXA_OP_STORE_EXCL) ? mon_q : 1'b0;
        end else if (state_q == SXA_ST_STX && (!stx_pass || beat_done)) begin
            mon_q <= 1'b0;
        end else if (snoop_valid && snoop_addr == mon_addr_q) begin
            mon_q <= 1'b0;
        end
    end
endmodule : sxa_stack_excl

`default_nettype wire

//--- sxa_mem_model.sv
// Memory partner: 64-word array answering with optional stalls.
// Assumes word addresses below 0x100.
`timescale 1ns/10ps
`default_nettype none
module sxa_mem_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [1:0] mem_size,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ready,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem_q [64];
    logic tick_q = 1'b0;
    logic [31:0] last_q = 32'h0;
    logic [1:0] size_q = 2'h0;
    assign mem_ready = mem_req && (!slow || tick_q);
    // Released bus shows inverse of last value
    assign mem_rdata = (mem_req && !mem_we) ? mem_q[mem_addr[7:2]] : ~last_q;
    always @(posedge clk) begin
        tick_q <= !tick_q;
        if (mem_ready) size_q <= mem_size;
        if (mem_ready && !mem_we) last_q <= mem_q[mem_addr[7:2]];
        if (mem_ready && mem_we) mem_q[mem_addr[7:2]] <= mem_wdata;
    end
endmodule : sxa_mem_model
`default_nettype wire

//--- sxa_stack_excl_monitor.sv
// Checker for the stack and exclusive sequencer ports.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module sxa_stack_excl_monitor
    import sxa_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic op_valid,
    input wire logic op_ready,
    input wire sxa_op_t op_code,
    input wire logic op_done,
    input wire logic mem_req,
    input wire logic mem_ready,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic sp_wr_en,
    input wire logic branch_en,
    input wire logic [31:0] branch_addr,
    input wire logic flags_we,
    input wire logic monitor_armed
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_wstep; mem_req && mem_ready && mem_we ##1 mem_req && mem_we; endsequence
    sequence s_rstep; mem_req && mem_ready && !mem_we ##1 mem_req && !mem_we; endsequence
    property p_flags; !flags_we; endproperty
    a_flags: assert property (p_flags) else $error("flags written");
    property p_down; s_wstep |-> mem_addr == $past(mem_addr) - SXA_WORD_STEP; endproperty
    a_down: assert property (p_down) else $error("store step wrong");
    property p_up; s_rstep |-> mem_addr == $past(mem_addr) + SXA_WORD_STEP; endproperty
    a_up: assert property (p_up) else $error("load step wrong");
    property p_hold; mem_req && !mem_ready |=> mem_req && $stable(mem_addr); endproperty
    a_hold: assert property (p_hold) else $error("beat dropped");
    property p_sp; sp_wr_en |-> op_done && !mem_req; endproperty
    a_sp: assert property (p_sp) else $error("early sp write");
    property p_br; branch_en |-> $past(op_done) && !branch_addr[0]; endproperty
    a_br: assert property (p_br) else $error("branch timing");
    property p_clr; op_valid && op_ready && op_code == SXA_OP_CLEAR_EXCL |-> ##2 !monitor_armed;
    endproperty
    a_clr: assert property (p_clr) else $error("monitor kept");
    property p_rdy; op_done |=> op_ready [*1] ##0 !op_done; endproperty
    a_rdy: assert property (p_rdy) else $error("done not single");
endmodule : sxa_stack_excl_monitor
bind sxa_stack_excl sxa_stack_excl_monitor sxa_stack_excl_monitor_inst (.clk, .nrst,
    .op_valid, .op_ready, .op_code, .op_done, .mem_req, .mem_ready, .mem_we, .mem_addr,
    .sp_wr_en, .branch_en, .branch_addr, .flags_we, .monitor_armed);
`default_nettype wire

//--- sxa_stack_excl_bench.sv
// Testbench for push, pop and exclusive access sequencing.
// Assumes the memory partner model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module sxa_stack_excl_bench;
    import sxa_pkg::*;
    logic clk = 0, nrst = 0, op_valid = 0, slow = 0, snoop_valid = 0;
    sxa_op_t op_code = SXA_OP_NONE;
    logic [15:0] op_reglist = 16'h0;
    logic [31:0] op_addr = 32'h0, op_store_data = 32'h0, sp_value = 32'h0, snoop_addr = 32'h0;
    logic [1:0] op_size = 2'h0;
    logic [31:0] reg_rd_data, mem_rdata, reg_wr_data, sp_wr_data, branch_addr;
    logic [31:0] mem_addr, mem_wdata, sp_log, wr_log [16];
    logic [3:0] reg_rd_idx, reg_wr_idx;
    logic [1:0] mem_size;
    logic op_ready, op_done, reg_wr_en, sp_wr_en, branch_en, thumb_flag, mem_req, mem_we;
    logic mem_ready, flags_we, monitor_armed;
    int errors = 0, compares = 0;
    assign reg_rd_data = 32'hC0DE_0000 | {28'h0, reg_rd_idx};
    sxa_stack_excl sxa_stack_excl_inst (.clk, .nrst, .op_valid, .op_code, .op_reglist,
        .op_addr, .op_size, .op_store_data, .sp_value, .reg_rd_data, .mem_ready, .mem_rdata,
        .snoop_valid, .snoop_addr, .op_ready, .op_done, .reg_rd_idx, .reg_wr_en, .reg_wr_idx,
        .reg_wr_data, .sp_wr_en, .sp_wr_data, .branch_en, .branch_addr, .thumb_flag, .mem_req,
        .mem_we, .mem_size, .mem_addr, .mem_wdata, .flags_we, .monitor_armed);
    sxa_mem_model sxa_mem_model_inst (.clk, .slow, .mem_req, .mem_we, .mem_size, .mem_addr,
        .mem_wdata, .mem_ready, .mem_rdata);
    initial forever #12.5 clk = !clk;
    always @(posedge clk) begin
        if (reg_wr_en) wr_log[reg_wr_idx] <= reg_wr_data;
        if (sp_wr_en) sp_log <= sp_wr_data;
    end
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task conclude;
        $display("checks %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task op(input sxa_op_t c, input logic [15:0] l, input logic [31:0] a,
            input logic [1:0] s, input logic [31:0] d);
        int n;
        @(posedge clk);
        #1 op_code = c;
        op_reglist = l;
        op_addr = a;
        op_size = s;
        op_store_data = d;
        op_valid = 1;
        @(posedge clk);
        #1 op_valid = 0;
        n = 0;
        while (op_done !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1 n++;
        end
        chk("done", 1, op_done);
    endtask : op
    task t_push;
        slow = 1;
        sp_value = 32'h80;
        op(SXA_OP_STORE_MULTI, 16'h0023, 0, 0, 0);
        chk("sp_we", 1, sp_wr_en);
        chk("sp", 32'h74, sp_wr_data);
        chk("stm_size", SXA_SIZE_WORD, sxa_mem_model_inst.size_q);
        chk("low", 32'hC0DE_0000, sxa_mem_model_inst.mem_q[29]);
        chk("mid", 32'hC0DE_0001, sxa_mem_model_inst.mem_q[30]);
        chk("top", 32'hC0DE_0005, sxa_mem_model_inst.mem_q[31]);
    endtask : t_push
    task t_pop;
        sp_value = 32'h74;
        op(SXA_OP_LOAD_MULTI, 16'h8003, 0, 0, 0);
        chk("sp_we", 1, sp_wr_en);
        @(posedge clk);
        #1 chk("r0", 32'hC0DE_0000, wr_log[0]);
        chk("r1", 32'hC0DE_0001, wr_log[1]);
        chk("sp", 32'h80, sp_log);
        chk("br_en", 1, branch_en);
        chk("branch", 32'hC0DE_0004, branch_addr);
        chk("thumb", 1, thumb_flag);
        slow = 0;
    endtask : t_pop
    task t_excl;
        op(SXA_OP_LOAD_EXCL, 0, 32'h7C, SXA_SIZE_WORD, 0);
        chk("ldx_we", 1, reg_wr_en);
        chk("ldx", 32'hC0DE_0005, reg_wr_data);
        chk("armed", 1, monitor_armed);
        op(SXA_OP_STORE_EXCL, 0, 32'h7C, SXA_SIZE_WORD, 32'h1234);
        chk("pass", SXA_STATUS_OK, reg_wr_data);
        chk("stored", 32'h1234, sxa_mem_model_inst.mem_q[31]);
        op(SXA_OP_LOAD_EXCL, 0, 32'h7C, SXA_SIZE_BYTE, 0);
        chk("ldxb", 32'h34, reg_wr_data);
        chk("ldxb_size", SXA_SIZE_BYTE, sxa_mem_model_inst.size_q);
        @(posedge clk);
        #1 snoop_addr = 32'h7C;
        snoop_valid = 1;
        @(posedge clk);
        #1 snoop_valid = 0;
        op(SXA_OP_STORE_EXCL, 0, 32'h7C, SXA_SIZE_BYTE, 32'h99);
        chk("snooped", SXA_STATUS_FAIL, reg_wr_data);
        chk("kept", 32'h1234, sxa_mem_model_inst.mem_q[31]);
        op(SXA_OP_LOAD_EXCL, 0, 32'h7C, SXA_SIZE_HALF, 0);
        chk("ldxh", 32'h1234, reg_wr_data);
        op(SXA_OP_CLEAR_EXCL, 0, 0, 0, 0);
        chk("cleared", 0, monitor_armed);
        op(SXA_OP_STORE_EXCL, 0, 32'h7C, SXA_SIZE_HALF, 32'h77);
        chk("clrfail", SXA_STATUS_FAIL, reg_wr_data);
        chk("flags", 0, flags_we);
    endtask : t_excl
    initial begin
        #50000;
        errors++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge clk);
        #1 nrst = 1;
        chk("ready", 1, op_ready);
        chk("thumb0", 1, thumb_flag);
        chk("mon0", 0, monitor_armed);
        t_push();
        t_pop();
        t_excl();
        conclude();
    end
endmodule : sxa_stack_excl_bench
`default_nettype wire
